// *** bench/gyrr_host.sv ***
// Host model: byte accesses on the register port.
// Assumes the bench calls wr and rd; requests change at falling edges.
module gyrr_host
(
  input wire logic clock_i,
  output logic [6:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  output logic port_busy_o
);
  logic hold = 1'b0;
  logic act = 1'b0;
  // Idle port at time zero
  initial
  begin
    reg_addr_o = 7'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Hold keeps a burst of byte reads in one transaction
  assign port_busy_o = hold | act;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock_i);
    act = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
    act = 1'b0;
    reg_wdata_o = ~d; // Released data must not look valid
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clock_i);
    act = 1'b1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
    act = 1'b0;
  endtask
endmodule

// *** bench/gyrr_regs_props.sv ***
// Checker for the register bank; sees only the bank's ports.
// Assumes one clock domain and the bind at the foot of this file.
module gyrr_regs_props
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic sample_strobe_i,
  input wire logic [1:0] full_scale_select_i,
  input wire logic [3:0] sensor_fifo_en_i,
  input wire logic data_ready_o,
  input wire logic [15:0] full_scale_dps_o,
  input wire logic [3:0] fifo_push_o,
  input wire logic fifo_clear_o,
  input wire logic path_clear_o,
  input wire logic spi_select_o,
  input wire logic i2c_enable_o,
  input wire logic sleep_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic wuc;
  logic wpc;
  // Writes to the two control registers
  assign wuc = reg_wr_i && reg_addr_i == 7'h6A;
  assign wpc = reg_wr_i && reg_addr_i == 7'h6B;
  ready_after_sample_a: assert property (
    sample_strobe_i && !sleep_o |=> data_ready_o) else $error("no ready");
  ready_needs_sample_a: assert property (
    data_ready_o |-> $past(sample_strobe_i) && !$past(sleep_o))
    else $error("ready without sample");
  fifo_clear_pulse_a: assert property (
    wuc && reg_wdata_i[2] |=> fifo_clear_o ##1 !fifo_clear_o)
    else $error("fifo clear pulse wrong");
  path_clear_pulse_a: assert property (
    wuc && reg_wdata_i[0] |=> path_clear_o ##1 !path_clear_o)
    else $error("path clear pulse wrong");
  soft_reset_all_a: assert property (
    wpc && reg_wdata_i[7] |=> soft_reset_o && path_clear_o && fifo_clear_o)
    else $error("soft reset incomplete");
  port_select_a: assert property (
    spi_select_o != i2c_enable_o) else $error("both ports alike");
  full_scale_map_a: assert property (
    full_scale_dps_o == (full_scale_select_i == 2'h0 ? 16'h00FA :
    full_scale_select_i == 2'h1 ? 16'h01F4 :
    full_scale_select_i == 2'h2 ? 16'h03E8 : 16'h07D0))
    else $error("full scale wrong");
  push_enable_a: assert property (
    sample_strobe_i && !sleep_o |=> {fifo_push_o[1], fifo_push_o[2],
    fifo_push_o[3]} == $past(sensor_fifo_en_i[2:0]))
    else $error("fifo push wrong");
endmodule
bind gyrr_regs gyrr_regs_props props (.*);

// *** bench/testbench.sv ***
// Self-checking bench for the gyro result and control register bank.
// Assumes gyrr_host drives the register port at falling edges.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gyrr_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic stb = 1'b0;
  logic [1:0] fs = 2'h0;
  gyrr_word_t smp [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [6:0] addr;
  logic wr, rd, busy, rdy, tde, spi, i2c, rda, slp;
  logic [7:0] wdata, rdata, b;
  logic [15:0] dps;
  gyrr_clk_src_e src, es;
  int err_total = 0;
  int num_checks = 0;
  always #25 clock_i = ~clock_i;
  gyrr_host host (.clock_i(clock_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
    .port_busy_o(busy));
  gyrr_regs DUT (.clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .port_busy_i(busy), .sample_strobe_i(stb), .temp_sample_i(smp[0]),
    .rate_x_sample_i(smp[1]), .rate_y_sample_i(smp[2]),
    .rate_z_sample_i(smp[3]), .full_scale_select_i(fs),
    .sensor_fifo_en_i(4'hA), .gyro_all_standby_i(1'b0),
    .data_ready_o(rdy), .full_scale_dps_o(dps), .fifo_read_allow_o(rda),
    .fifo_write_allow_o(), .fifo_push_o(), .fifo_clear_o(),
    .path_clear_o(), .spi_select_o(spi), .i2c_enable_o(i2c),
    .sleep_o(slp), .temp_enable_o(tde), .clock_source_o(src),
    .soft_reset_o());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One sample strobe; ready is due one cycle later unless asleep
  task automatic take(input gyrr_word_t t, x, y, z, input logic er);
    @(negedge clock_i);
    smp = '{t, x, y, z};
    stb = 1'b1;
    @(negedge clock_i);
    stb = 1'b0;
    chk(rdy, er);
  endtask
  task automatic rd_word(input logic [6:0] a, input gyrr_word_t exp);
    logic [7:0] h;
    host.rd(a, h);
    host.rd(a + 7'h01, b);
    chk({h, b}, exp);
  endtask
  task automatic t_results();
    take(16'hFF38, 16'h8001, 16'h7FFF, 16'h0102, 1'b1);
    // Let the idle port refresh the copy before the burst starts
    @(negedge clock_i);
    host.hold = 1'b1;
    rd_word(7'h41, 16'hFF38);
    rd_word(7'h43, 16'h8001);
    rd_word(7'h45, 16'h7FFF);
    rd_word(7'h47, 16'h0102);
    take(16'h1111, 16'h2222, 16'h3333, 16'h4444, 1'b1);
    rd_word(7'h43, 16'h8001);
    host.hold = 1'b0;
    repeat (2) @(negedge clock_i);
    rd_word(7'h45, 16'h3333);
    $display("results done");
  endtask
  task automatic t_control();
    host.wr(7'h6A, 8'hF1);
    host.rd(7'h6A, b);
    chk(b, 8'h50);
    chk({spi, i2c, rda}, 3'h5);
    rd_word(7'h47, 16'h0000);
    host.wr(7'h6A, 8'h14); // Reads off first
    host.rd(7'h6A, b);
    chk(b, 8'h10);
    chk(rda, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      host.wr(7'h6B, c[7:0]);
      es = (c == 0 || c == 6) ? GYRR_SRC_OSC :
        (c == 7) ? GYRR_SRC_RSVD : GYRR_SRC_PLL;
      chk(src, es);
    end
    for (int f = 0; f < 4; f++)
    begin
      @(negedge clock_i);
      fs = f[1:0];
      #1;
      chk(dps, 16'h00FA << f);
    end
    $display("control done");
  endtask
  task automatic t_power();
    host.wr(7'h6B, 8'h79);
    host.rd(7'h6B, b);
    chk(b, 8'h49);
    chk({slp, tde}, 2'h2);
    take(16'h0005, 16'h0006, 16'h0007, 16'h0008, 1'b0);
    host.wr(7'h6B, 8'h80);
    // Soft reset lands one cycle after the write; read after it
    @(negedge clock_i);
    host.rd(7'h6A, b);
    chk(b, 8'h00);
    host.rd(7'h6B, b);
    chk(b, 8'h01);
    chk(src, GYRR_SRC_PLL);
    $display("power done");
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    host.rd(7'h6B, b);
    chk(b, 8'h01);
    t_results();
    t_control();
    t_power();
    close_out();
  end
  // Watchdog against a hung port
  initial
  begin
    #1ms;
    err_total++;
    close_out();
  end
endmodule

// *** hdl/gyrr_defs.svh ***
// Constants for the gyro result and control register bank.
// Assumes an 8-bit register port with 7-bit addresses from the serial core.
`ifndef GYRR_DEFS_SVH
`define GYRR_DEFS_SVH
`define GYRR_ADDR_TEMP_H 7'h41
`define GYRR_ADDR_TEMP_L 7'h42
`define GYRR_ADDR_RATE_X_H 7'h43
`define GYRR_ADDR_RATE_X_L 7'h44
`define GYRR_ADDR_RATE_Y_H 7'h45
`define GYRR_ADDR_RATE_Y_L 7'h46
`define GYRR_ADDR_RATE_Z_H 7'h47
`define GYRR_ADDR_RATE_Z_L 7'h48
`define GYRR_ADDR_USER_CTRL 7'h6A
`define GYRR_ADDR_PWR_CLK 7'h6B
// User control fields
`define GYRR_UC_FIFO_RD_EN 6
`define GYRR_UC_PORT_SEL 4
`define GYRR_UC_FIFO_CLR 2
`define GYRR_UC_PATH_CLR 0
`define GYRR_UC_MASK 8'h50
`define GYRR_UC_RESET 8'h00
// Power and clock control fields
`define GYRR_PC_DEV_RESET 7
`define GYRR_PC_SLEEP 6
`define GYRR_PC_TEMPERATURE_DISABLE 3
`define GYRR_PC_CLK_HI 2
`define GYRR_PC_MASK 8'h4F
`define GYRR_PC_RESET 8'h01
`define GYRR_CLK_OSC_A 3'h0
`define GYRR_CLK_OSC_B 3'h6
`define GYRR_CLK_RSVD 3'h7
`define GYRR_FS_DPS_0 16'h00FA
`define GYRR_FS_DPS_1 16'h01F4
`define GYRR_FS_DPS_2 16'h03E8
`define GYRR_FS_DPS_3 16'h07D0
`define GYRR_DATA_ZERO 16'h0000
`define GYRR_NUM_CH 4
`endif

// *** hdl/gyrr_pkg.sv ***
// Types shared by the gyro result and control register bank.
// Assumes gyrr_defs.svh is on the include path.
package gyrr_pkg;
  typedef enum logic [1:0] {GYRR_SRC_OSC, GYRR_SRC_PLL, GYRR_SRC_RSVD}
    gyrr_clk_src_e;
  typedef logic [15:0] gyrr_word_t;
endpackage

// *** hdl/gyrr_regs.sv ***
// Result and control register bank of a three-axis rate sensor.
// Assumes a serial core (I2C or SPI) on clock_i presenting byte accesses
// with a busy level that spans each whole transaction.
`include "gyrr_defs.svh"

// Function
// - Internal results load once per sample at the output data rate.
// - Host copy refreshes from internal set only when the port is idle.
// - Burst reads return bytes all from one sampling instant.
// - Data-ready pulses each time the results update.
// - Temperature is signed 16 bits over high and low bytes.
// - Rates are 16-bit two's complement, high byte first, X Y Z.
// - Full-scale code 0..3 gives 250, 500, 1000, 2000 deg/s.
// - FIFO reads blocked while read-enable is 0; writes still allowed.
// - FIFO keeps contents unless FIFO reset, soft reset or power cycle.
// - Port-select bit set disables I2C and enables SPI.
// - Writing FIFO-reset bit clears FIFO and the bit self-clears.
// - Path-clear bit resets signal paths, clears results, self-clears.
// - Device-reset bit restores all registers, self-clears when done.
// - Sleep bit places the device in low-power sleep.
// - Temperature-disable bit turns the temperature sensor off.
// - Clock code 0,6 oscillator; 1..5 PLL; 7 reserved.
// - PLL is the clock source after power-up.
// - Oscillator allows running with all gyro axes disabled.
// - Sensor pair enters FIFO per sample only when its enable is set.
module gyrr_regs
(
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port from the serial core
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic port_busy_i,
  // Sample source at the output data rate
  input wire logic sample_strobe_i,
  input wire gyrr_pkg::gyrr_word_t temp_sample_i,
  input wire gyrr_pkg::gyrr_word_t rate_x_sample_i,
  input wire gyrr_pkg::gyrr_word_t rate_y_sample_i,
  input wire gyrr_pkg::gyrr_word_t rate_z_sample_i,
  input wire logic [1:0] full_scale_select_i,
  input wire logic [3:0] sensor_fifo_en_i,
  input wire logic gyro_all_standby_i,
  // Results toward the rest of the chip
  output logic data_ready_o,
  output logic [15:0] full_scale_dps_o,
  output logic fifo_read_allow_o,
  output logic fifo_write_allow_o,
  output logic [3:0] fifo_push_o,
  output logic fifo_clear_o,
  output logic path_clear_o,
  output logic spi_select_o,
  output logic i2c_enable_o,
  output logic sleep_o,
  output logic temp_enable_o,
  output gyrr_pkg::gyrr_clk_src_e clock_source_o,
  output logic soft_reset_o
);
  import gyrr_pkg::*;

  logic [7:0] user_ctrl_r;
  logic [7:0] pwr_clk_r;
  logic fifo_clr_r;
  logic path_clr_r;
  logic dev_rst_r;
  logic uc_wr;
  logic pc_wr;
  logic sample_take;
  logic port_idle;
  gyrr_word_t vis_w [`GYRR_NUM_CH];
  gyrr_word_t raw_w [`GYRR_NUM_CH];
  gyrr_word_t int_w [`GYRR_NUM_CH];
  logic [7:0] rdata_nxt;

  assign uc_wr = reg_wr_i && (reg_addr_i == `GYRR_ADDR_USER_CTRL);
  assign pc_wr = reg_wr_i && (reg_addr_i == `GYRR_ADDR_PWR_CLK);
  assign port_idle = !port_busy_i;

  // Temperature channel is held when disabled; rates keep sampling
  assign sample_take = sample_strobe_i && !pwr_clk_r[`GYRR_PC_SLEEP];
  assign raw_w[0] = temp_sample_i;
  assign raw_w[1] = rate_x_sample_i;
  assign raw_w[2] = rate_y_sample_i;
  assign raw_w[3] = rate_z_sample_i;

  // One shadowed channel per sensor: temp, X, Y, Z
  genvar ch;
  generate
    for (ch = 0; ch < `GYRR_NUM_CH; ch = ch + 1)
    begin : g_ch
      logic take;
      assign take = sample_take
        && !(ch == 0 && pwr_clk_r[`GYRR_PC_TEMPERATURE_DISABLE]);
      gyrr_shadow u_shadow
      (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .clear_i(path_clr_r || dev_rst_r),
        .sample_i(take),
        .data_i(raw_w[ch]),
        .idle_i(port_idle),
        .internal_o(int_w[ch]),
        .visible_o(vis_w[ch])
      );
      // FIFO push of this pair only with its enable
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
        if (!nrst_i)
          fifo_push_o[ch] <= 1'b0;
        else
          fifo_push_o[ch] <= take && sensor_fifo_en_i[3 - ch];
      end
    end
  endgenerate

  // Data-ready pulse rises on the same edge as each internal result update
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      data_ready_o <= 1'b0;
    else
      data_ready_o <= sample_take;
  end

  // User control: only documented bits stored, self-clearing strobes apart
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      user_ctrl_r <= `GYRR_UC_RESET;
    else if (dev_rst_r)
      user_ctrl_r <= `GYRR_UC_RESET;
    else if (uc_wr)
      user_ctrl_r <= reg_wdata_i & `GYRR_UC_MASK;
  end

  // Reset strobes last one cycle then read back as zero
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fifo_clr_r <= 1'b0;
      path_clr_r <= 1'b0;
    end
    else
    begin
      fifo_clr_r <= uc_wr && reg_wdata_i[`GYRR_UC_FIFO_CLR];
      path_clr_r <= uc_wr && reg_wdata_i[`GYRR_UC_PATH_CLR];
    end
  end

  // Power and clock control; PLL code at reset
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pwr_clk_r <= `GYRR_PC_RESET;
    else if (dev_rst_r)
      pwr_clk_r <= `GYRR_PC_RESET;
    else if (pc_wr)
      pwr_clk_r <= reg_wdata_i & `GYRR_PC_MASK;
  end

  // Soft reset strobe; bit reads 1 only for the reset cycle
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      dev_rst_r <= 1'b0;
    else
      dev_rst_r <= pc_wr && reg_wdata_i[`GYRR_PC_DEV_RESET];
  end

  // Soft reset also empties the FIFO; disabled reads never do
  assign fifo_clear_o = fifo_clr_r || dev_rst_r;
  assign path_clear_o = path_clr_r || dev_rst_r;
  assign soft_reset_o = dev_rst_r;
  assign fifo_read_allow_o = user_ctrl_r[`GYRR_UC_FIFO_RD_EN];
  assign fifo_write_allow_o = 1'b1;
  assign spi_select_o = user_ctrl_r[`GYRR_UC_PORT_SEL];
  assign i2c_enable_o = !user_ctrl_r[`GYRR_UC_PORT_SEL];
  assign sleep_o = pwr_clk_r[`GYRR_PC_SLEEP];
  assign temp_enable_o = !pwr_clk_r[`GYRR_PC_TEMPERATURE_DISABLE];

  // Clock source decode; all-standby with PLL would starve the clock
  always_comb
  begin
    case (pwr_clk_r[`GYRR_PC_CLK_HI:0])
      `GYRR_CLK_OSC_A: clock_source_o = GYRR_SRC_OSC;
      `GYRR_CLK_OSC_B: clock_source_o = GYRR_SRC_OSC;
      `GYRR_CLK_RSVD: clock_source_o = GYRR_SRC_RSVD;
      default:
        clock_source_o = gyro_all_standby_i ? GYRR_SRC_OSC
                                            : GYRR_SRC_PLL;
    endcase
  end

  // Full-scale range for the rate channels
  always_comb
  begin
    case (full_scale_select_i)
      2'h0: full_scale_dps_o = `GYRR_FS_DPS_0;
      2'h1: full_scale_dps_o = `GYRR_FS_DPS_1;
      2'h2: full_scale_dps_o = `GYRR_FS_DPS_2;
      2'h3: full_scale_dps_o = `GYRR_FS_DPS_3;
      default: full_scale_dps_o = `GYRR_FS_DPS_0;
    endcase
  end

  // Read mux over the host copy, high byte at the lower address
  always_comb
  begin
    case (reg_addr_i)
      `GYRR_ADDR_TEMP_H: rdata_nxt = vis_w[0][15:8];
      `GYRR_ADDR_TEMP_L: rdata_nxt = vis_w[0][7:0];
      `GYRR_ADDR_RATE_X_H: rdata_nxt = vis_w[1][15:8];
      `GYRR_ADDR_RATE_X_L: rdata_nxt = vis_w[1][7:0];
      `GYRR_ADDR_RATE_Y_H: rdata_nxt = vis_w[2][15:8];
      `GYRR_ADDR_RATE_Y_L: rdata_nxt = vis_w[2][7:0];
      `GYRR_ADDR_RATE_Z_H: rdata_nxt = vis_w[3][15:8];
      `GYRR_ADDR_RATE_Z_L: rdata_nxt = vis_w[3][7:0];
      `GYRR_ADDR_USER_CTRL: rdata_nxt = user_ctrl_r;
      `GYRR_ADDR_PWR_CLK: rdata_nxt = pwr_clk_r | {dev_rst_r, 7'h00};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data registered on the read strobe
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_nxt;
  end
endmodule

// *** hdl/gyrr_shadow.sv ***
// One result channel: internal sample word and its host-facing copy.
// Assumes the strobes come from logic on the same clock.
`include "gyrr_defs.svh"
module gyrr_shadow
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic clear_i,
  input wire logic sample_i,
  input wire gyrr_pkg::gyrr_word_t data_i,
  input wire logic idle_i,
  output gyrr_pkg::gyrr_word_t internal_o,
  output gyrr_pkg::gyrr_word_t visible_o
);
  import gyrr_pkg::*;

  // Internal set takes every sample
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      internal_o <= `GYRR_DATA_ZERO;
    else if (clear_i)
      internal_o <= `GYRR_DATA_ZERO;
    else if (sample_i)
      internal_o <= data_i;
  end

  // Copy follows only while the port is idle, so bursts stay coherent
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      visible_o <= `GYRR_DATA_ZERO;
    else if (clear_i)
      visible_o <= `GYRR_DATA_ZERO;
    else if (idle_i)
      visible_o <= internal_o;
  end
endmodule
